// ==== scc_counter.sv ====
// Purpose: 16-bit up/down counter with input capture behind an 8-bit I/O bus.
// Assumes: All inputs are synchronous to core_clk; bus strobes last one cycle.
// Notes:   Read data is registered and appears one cycle after the read strobe.
`timescale 1ns/1ps
module scc_counter
	import scc_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       nrst,
	input  wire logic [5:0] ioAddr,
	input  wire logic [7:0] ioWrData,
	input  wire logic       ioWr,
	input  wire logic       ioRd,
	output logic      [7:0] ioRdData,
	input  wire logic       capturePin,
	input  wire logic       comparatorOutput,
	input  wire logic       comparatorSelect,
	input  wire logic       extClkPin,
	input  wire logic       captureAck,
	input  wire logic       overflowAck,
	output logic            captureIrq,
	output logic            overflowIrq,
	output logic            atCeiling,
	output logic            atFloor
);
	logic [15:0] count;
	logic [15:0] capture;
	logic [15:0] cmpA;
	logic [15:0] cmpB;
	logic [7:0]  hold;
	logic [7:0]  ctrlA;
	scc_ctrlb_t  ctrlB;
	logic        capFlag;
	logic        ovfFlag;
	logic        capIrqEn;
	logic        ovfIrqEn;
	logic        countDown;
	logic [9:0]  preCnt;
	logic        extPrev;
	logic [FILTER_SAMPLES-2:0] filt;
	logic        filtered;
	logic        edgeIn;
	logic        edgePrev;

	logic [15:0] next_count;
	logic        next_down;
	logic        next_capFlag;
	logic        next_ovfFlag;

	wire wr = ioWr;
	wire rd = ioRd;
	wire cntLowWr  = wr && ioAddr == ADDR_CNT_L;
	wire cntLowRd  = rd && ioAddr == ADDR_CNT_L;
	wire capLowWr  = wr && ioAddr == ADDR_CAP_L;
	wire capLowRd  = rd && ioAddr == ADDR_CAP_L;
	wire cmpALowWr = wr && ioAddr == ADDR_CMPA_L;
	wire cmpBLowWr = wr && ioAddr == ADDR_CMPB_L;
	wire anyHighWr = wr && (ioAddr == ADDR_CNT_H || ioAddr == ADDR_CAP_H
		|| ioAddr == ADDR_CMPA_H || ioAddr == ADDR_CMPB_H);
	wire flagsWr = wr && ioAddr == ADDR_FLAGS;
	wire maskWr  = wr && ioAddr == ADDR_MASK;
	// Requests use the enable as it stands after this edge, so a disable never leaves a request behind.
	wire next_capIrqEn = maskWr ? ioWrData[FLAG_CAP] : capIrqEn;
	wire next_ovfIrqEn = maskWr ? ioWrData[FLAG_OVF] : ovfIrqEn;

	wire [3:0] mode = {ctrlB.wgmHi, ctrlA[1:0]};
	wire dual    = MODE_DUAL[mode];
	wire icrTop  = MODE_ICR_TOP[mode];
	wire ocraTop = MODE_OCRA_TOP[mode];
	wire fast    = MODE_FAST[mode];

	wire [15:0] fixedTop =
		(mode == 4'h1 || mode == 4'h5) ? TOP_8BIT :
		(mode == 4'h2 || mode == 4'h6) ? TOP_9BIT :
		(mode == 4'h3 || mode == 4'h7) ? TOP_10BIT : TOP_MAX;
	wire [15:0] top = icrTop ? capture : ocraTop ? cmpA : fixedTop;

	// The external source is edge detected here, so its rate must stay below half of core_clk.
	wire extRise = extClkPin && !extPrev;
	wire extFall = !extClkPin && extPrev;
	wire tick =
		ctrlB.clkSel == CS_CLK     ? 1'b1 :
		ctrlB.clkSel == CS_DIV8    ? (preCnt & PRE_DIV8) == PRE_DIV8 :
		ctrlB.clkSel == CS_DIV64   ? (preCnt & PRE_DIV64) == PRE_DIV64 :
		ctrlB.clkSel == CS_DIV256  ? (preCnt & PRE_DIV256) == PRE_DIV256 :
		ctrlB.clkSel == CS_DIV1024 ? preCnt == PRE_DIV1024 :
		ctrlB.clkSel == CS_EXT_FALL ? extFall :
		ctrlB.clkSel == CS_EXT_RISE ? extRise : 1'b0;

	wire ovfPoint = dual ? (countDown && count == 16'h0001)
		: (count == (fast ? top : TOP_MAX));
	wire ovfSet = tick && !cntLowWr && ovfPoint;

	wire capSrc = comparatorSelect ? comparatorOutput : capturePin;
	wire filtAll1 = &{filt, capSrc};
	wire filtAll0 = ~|{filt, capSrc};
	wire edgeSrc = ctrlB.filtEn ? filtered : capSrc;
	wire edgeSeen = ctrlB.edgeRise ? (edgeIn && !edgePrev)
		: (!edgeIn && edgePrev);
	// In modes where capture defines the top, the detector is shut off.
	wire capSet = edgeSeen && !icrTop;

	always_comb begin
		next_count = count;
		next_down = countDown;
		if (cntLowWr) begin
			next_count = {hold, ioWrData};
		end else if (tick) begin
			if (dual) begin
				if (countDown && count == RST_WORD) begin
					next_down = 1'b0;
					next_count = count + 16'h0001;
				end else if (!countDown && count >= top) begin
					next_down = 1'b1;
					next_count = count - 16'h0001;
				end else if (countDown) begin
					next_count = count - 16'h0001;
				end else begin
					next_count = count + 16'h0001;
				end
			end else if (count == top) begin
				next_count = RST_WORD;
				next_down = 1'b0;
			end else begin
				next_count = count + 16'h0001;
				next_down = 1'b0;
			end
		end
	end

	// Set wins over clear so that no event is lost.
	always_comb begin
		next_capFlag = capSet || (capFlag
			&& !captureAck && !(flagsWr && ioWrData[FLAG_CAP]));
		next_ovfFlag = ovfSet || (ovfFlag
			&& !overflowAck && !(flagsWr && ioWrData[FLAG_OVF]));
	end

	wire [7:0] flagsRd = 8'(capFlag) << FLAG_CAP | 8'(ovfFlag) << FLAG_OVF;
	wire [7:0] maskRd  = 8'(capIrqEn) << FLAG_CAP | 8'(ovfIrqEn) << FLAG_OVF;
	wire [7:0] rdMux =
		ioAddr == ADDR_CNT_L  ? count[7:0] :
		ioAddr == ADDR_CNT_H  ? hold :
		ioAddr == ADDR_CAP_L  ? capture[7:0] :
		ioAddr == ADDR_CAP_H  ? hold :
		ioAddr == ADDR_CMPA_L ? cmpA[7:0] :
		ioAddr == ADDR_CMPA_H ? cmpA[15:8] :
		ioAddr == ADDR_CMPB_L ? cmpB[7:0] :
		ioAddr == ADDR_CMPB_H ? cmpB[15:8] :
		ioAddr == ADDR_CTRL_A ? ctrlA :
		ioAddr == ADDR_CTRL_B ? ctrlB :
		ioAddr == ADDR_FLAGS  ? flagsRd :
		ioAddr == ADDR_MASK   ? maskRd : RST_BYTE;

	wire capWrOk = capLowWr && icrTop;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			count <= RST_WORD;
			countDown <= 1'b0;
			capture <= RST_WORD;
		end else begin
			count <= next_count;
			countDown <= next_down;
			if (capWrOk) begin
				capture <= {hold, ioWrData};
			end else if (capSet) begin
				capture <= count;
			end
		end
	end

	// One byte serves every wide register, so nested accesses corrupt each other.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			hold <= RST_BYTE;
		end else if (anyHighWr) begin
			hold <= ioWrData;
		end else if (cntLowRd) begin
			hold <= count[15:8];
		end else if (capLowRd) begin
			hold <= capture[15:8];
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cmpA <= RST_WORD;
			cmpB <= RST_WORD;
		end else if (cmpALowWr) begin
			cmpA <= {hold, ioWrData};
		end else if (cmpBLowWr) begin
			cmpB <= {hold, ioWrData};
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ctrlA <= RST_BYTE;
			ctrlB <= scc_ctrlb_t'(RST_BYTE);
			capIrqEn <= 1'b0;
			ovfIrqEn <= 1'b0;
		end else if (wr && ioAddr == ADDR_CTRL_A) begin
			ctrlA <= ioWrData;
		end else if (wr && ioAddr == ADDR_CTRL_B) begin
			ctrlB <= scc_ctrlb_t'(ioWrData);
		end else if (wr && ioAddr == ADDR_MASK) begin
			capIrqEn <= ioWrData[FLAG_CAP];
			ovfIrqEn <= ioWrData[FLAG_OVF];
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			capFlag <= 1'b0;
			ovfFlag <= 1'b0;
			captureIrq <= 1'b0;
			overflowIrq <= 1'b0;
		end else begin
			capFlag <= next_capFlag;
			ovfFlag <= next_ovfFlag;
			captureIrq <= next_capFlag && next_capIrqEn;
			overflowIrq <= next_ovfFlag && next_ovfIrqEn;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			atCeiling <= 1'b0;
			atFloor <= 1'b1;
			ioRdData <= RST_BYTE;
		end else begin
			atCeiling <= next_count == top;
			atFloor <= next_count == RST_WORD;
			ioRdData <= rd ? rdMux : RST_BYTE;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			preCnt <= 10'h000;
			extPrev <= 1'b0;
		end else begin
			preCnt <= preCnt + 10'h001;
			extPrev <= extClkPin;
		end
	end

	// The filter costs four cycles of latency but rejects short spikes.
	// The live input counts as the fourth sample, which keeps the added delay at exactly four.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			filt <= '0;
			filtered <= 1'b0;
			edgeIn <= 1'b0;
			edgePrev <= 1'b0;
		end else begin
			filt <= {filt[FILTER_SAMPLES-3:0], capSrc};
			if (filtAll1) begin
				filtered <= 1'b1;
			end else if (filtAll0) begin
				filtered <= 1'b0;
			end
			edgeIn <= edgeSrc;
			edgePrev <= edgeIn;
		end
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);

	sequence s_capLowRead;
		rd && ioAddr == ADDR_CAP_L;
	endsequence

	property p_cntWrite;
		cntLowWr |=> count == $past({hold, ioWrData});
	endproperty
	a_cntWrite: assert property (p_cntWrite) else $error("counter write lost");

	property p_stopped;
		(ctrlB.clkSel == CS_STOP && !cntLowWr) |=> $stable(count);
	endproperty
	a_stopped: assert property (p_stopped) else $error("counter moved while stopped");

	property p_step;
		(tick && !cntLowWr && next_count != RST_WORD) |=>
			(count == 16'($past(count) + 16'h0001) || count == 16'($past(count) - 16'h0001));
	endproperty
	a_step: assert property (p_step) else $error("count step not one");

	property p_cntHold;
		cntLowRd && !anyHighWr |=> hold == $past(count[15:8]);
	endproperty
	a_cntHold: assert property (p_cntHold) else $error("shared byte not loaded");

	property p_capHold;
		s_capLowRead |=> hold == $past(capture[15:8]);
	endproperty
	a_capHold: assert property (p_capHold) else $error("capture high not held");

	property p_capture;
		(capSet && !capWrOk) |=> capture == $past(count) && capFlag;
	endproperty
	a_capture: assert property (p_capture) else $error("capture copy or flag wrong");

	property p_irqGate;
		captureIrq |-> capFlag && capIrqEn;
	endproperty
	a_irqGate: assert property (p_irqGate) else $error("capture irq without enable");

	property p_ackClear;
		(captureAck && !capSet) |=> !capFlag;
	endproperty
	a_ackClear: assert property (p_ackClear) else $error("capture flag not cleared");

	property p_cmpRead;
		(rd && (ioAddr == ADDR_CMPA_H || ioAddr == ADDR_CMPB_H)) |=> $stable(hold);
	endproperty
	a_cmpRead: assert property (p_cmpRead) else $error("compare read touched shared byte");

	property p_capLock;
		(capLowWr && !icrTop && !capSet) |=> $stable(capture);
	endproperty
	a_capLock: assert property (p_capLock) else $error("capture written in wrong mode");

	property p_floor;
		atFloor == (count == RST_WORD);
	endproperty
	a_floor: assert property (p_floor) else $error("floor indication wrong");
endmodule

// ==== scc_cpu_model.sv ====
// Purpose: Processor side of the 8-bit I/O bus that drives the counter block.
// Assumes: One-cycle strobes; read data is settled one cycle after the strobe.
// Notes:   Released lines carry inverted values so that stale data never looks valid.
`timescale 1ns/1ps
module scc_cpu_model
	import scc_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic [7:0] ioRdData,
	output logic      [5:0] ioAddr,
	output logic      [7:0] ioWrData,
	output logic            ioWr,
	output logic            ioRd
);
	initial begin
		ioAddr = 6'h3f;
		ioWrData = 8'h00;
		ioWr = 1'b0;
		ioRd = 1'b0;
	end

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge core_clk);
		#1;
		ioAddr = a;
		ioWrData = d;
		ioWr = 1'b1;
		@(posedge core_clk);
		#1;
		ioWr = 1'b0;
		ioAddr = ~a;
		ioWrData = ~d;
	endtask

	task automatic rd(input logic [5:0] a, output logic [7:0] d);
		@(posedge core_clk);
		#1;
		ioAddr = a;
		ioRd = 1'b1;
		@(posedge core_clk);
		#1;
		ioRd = 1'b0;
		ioAddr = ~a;
		d = ioRdData;
	endtask

	task automatic wr16(input logic [5:0] a, input logic [15:0] v);
		wr(a + 6'h01, v[15:8]);
		wr(a, v[7:0]);
	endtask

	task automatic rd16(input logic [5:0] a, output logic [15:0] v);
		rd(a, v[7:0]);
		rd(a + 6'h01, v[15:8]);
	endtask
endmodule

// ==== scc_pkg.sv ====
// Purpose: Shared constants and types for the 16-bit counter with capture.
// Assumes: 8-bit I/O bus with 6-bit location numbers, one system clock.
// Notes:   Mode tables are bit masks indexed by the 4-bit waveform mode.
package scc_pkg;
	localparam logic [5:0] ADDR_CNT_L  = 6'h00;
	localparam logic [5:0] ADDR_CNT_H  = 6'h01;
	localparam logic [5:0] ADDR_CAP_L  = 6'h02;
	localparam logic [5:0] ADDR_CAP_H  = 6'h03;
	localparam logic [5:0] ADDR_CMPA_L = 6'h04;
	localparam logic [5:0] ADDR_CMPA_H = 6'h05;
	localparam logic [5:0] ADDR_CMPB_L = 6'h06;
	localparam logic [5:0] ADDR_CMPB_H = 6'h07;
	localparam logic [5:0] ADDR_CTRL_A = 6'h08;
	localparam logic [5:0] ADDR_CTRL_B = 6'h09;
	localparam logic [5:0] ADDR_FLAGS  = 6'h0a;
	localparam logic [5:0] ADDR_MASK   = 6'h0b;

	localparam int FLAG_OVF = 2;
	localparam int FLAG_CAP = 5;

	localparam logic [15:0] MODE_DUAL     = 16'h0f0e;
	localparam logic [15:0] MODE_ICR_TOP  = 16'h5500;
	localparam logic [15:0] MODE_OCRA_TOP = 16'h8a10;
	localparam logic [15:0] MODE_FAST     = 16'hc0e0;

	localparam logic [15:0] TOP_MAX   = 16'hffff;
	localparam logic [15:0] TOP_8BIT  = 16'h00ff;
	localparam logic [15:0] TOP_9BIT  = 16'h01ff;
	localparam logic [15:0] TOP_10BIT = 16'h03ff;

	localparam logic [9:0] PRE_DIV8    = 10'h007;
	localparam logic [9:0] PRE_DIV64   = 10'h03f;
	localparam logic [9:0] PRE_DIV256  = 10'h0ff;
	localparam logic [9:0] PRE_DIV1024 = 10'h3ff;

	localparam int FILTER_SAMPLES = 4;

	localparam logic [7:0]  RST_BYTE = 8'h00;
	localparam logic [15:0] RST_WORD = 16'h0000;

	typedef enum logic [2:0] {
		CS_STOP, CS_CLK, CS_DIV8, CS_DIV64,
		CS_DIV256, CS_DIV1024, CS_EXT_FALL, CS_EXT_RISE
	} scc_clksel_t;

	typedef struct packed {
		logic        filtEn;
		logic        edgeRise;
		logic        spare;
		logic [1:0]  wgmHi;
		scc_clksel_t clkSel;
	} scc_ctrlb_t;
endpackage

// ==== test_scc_counter.sv ====
// Purpose: Self-checking bench for the 16-bit counter with capture.
// Assumes: Counter is stopped whenever a value is read back and compared.
// Notes:   Capture waits are bounded; a missing capture ends the run.
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module test_scc_counter
	import scc_pkg::*;
;
	logic        core_clk = 1'b0;
	logic        nrst = 1'b0;
	logic        capturePin = 1'b0;
	logic        comparatorOutput = 1'b0;
	logic        comparatorSelect = 1'b0;
	logic        extClkPin = 1'b0;
	logic        captureAck = 1'b0;
	logic        overflowAck = 1'b0;
	wire  [5:0]  ioAddr;
	wire  [7:0]  ioWrData;
	wire  [7:0]  ioRdData;
	wire         ioWr;
	wire         ioRd;
	wire         captureIrq;
	wire         overflowIrq;
	wire         atCeiling;
	wire         atFloor;
	logic [15:0] v;
	logic [7:0]  b;
	int          fails = 0;
	int          checked = 0;

	always #25 core_clk = ~core_clk;

	scc_counter scc_counter_i (.core_clk(core_clk), .nrst(nrst), .ioAddr(ioAddr), .ioWrData(ioWrData),
		.ioWr(ioWr), .ioRd(ioRd), .ioRdData(ioRdData), .capturePin(capturePin),
		.comparatorOutput(comparatorOutput), .comparatorSelect(comparatorSelect), .extClkPin(extClkPin),
		.captureAck(captureAck), .overflowAck(overflowAck), .captureIrq(captureIrq),
		.overflowIrq(overflowIrq), .atCeiling(atCeiling), .atFloor(atFloor));

	scc_cpu_model scc_cpu_model_i (.core_clk(core_clk), .ioRdData(ioRdData), .ioAddr(ioAddr),
		.ioWrData(ioWrData), .ioWr(ioWr), .ioRd(ioRd));

	function automatic logic [7:0] ctlb(input logic e, input logic [1:0] w, input scc_clksel_t c);
		scc_ctrlb_t s;
		s = '{filtEn: 1'b0, edgeRise: e, spare: 1'b0, wgmHi: w, clkSel: c};
		return s;
	endfunction

	task finish_test;
		$display("Comparisons %0d, mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	// Each pulse is held for three cycles so the edge detector sees it cleanly.
	task automatic ext(input int n);
		repeat (n) begin
			idle(1);
			extClkPin = 1'b1;
			idle(3);
			extClkPin = 1'b0;
			idle(3);
		end
	endtask

	task automatic waitIrq;
		int i;
		for (i = 0; i < 12 && captureIrq !== 1'b1; i++)
			idle(1);
		if (i == 12) begin
			fails++;
			finish_test;
		end
	endtask

	task automatic pulse(ref logic s);
		idle(1);
		s = 1'b1;
		idle(1);
		s = 1'b0;
		idle(1);
	endtask

	initial begin
		idle(10);
		nrst = 1'b1;
		scc_cpu_model_i.rd16(ADDR_CNT_L, v);
		`CHK(v, RST_WORD)
		scc_cpu_model_i.rd16(ADDR_CAP_L, v);
		`CHK(v, RST_WORD)
		`CHK(atFloor, 1'b1)
		scc_cpu_model_i.rd(6'h3f, b);
		`CHK(b, 8'h00)
		scc_cpu_model_i.wr16(ADDR_CNT_L, 16'h01ff);
		idle(20);
		scc_cpu_model_i.rd16(ADDR_CNT_L, v);
		`CHK(v, 16'h01ff)
		scc_cpu_model_i.wr(ADDR_CNT_H, 8'hab);
		scc_cpu_model_i.wr(ADDR_CNT_L, 8'h12);
		scc_cpu_model_i.wr(ADDR_CMPA_H, 8'h5c);
		scc_cpu_model_i.wr(ADDR_CMPA_L, 8'h34);
		scc_cpu_model_i.rd(ADDR_CNT_L, b);
		`CHK(b, 8'h12)
		scc_cpu_model_i.rd(ADDR_CMPA_L, b);
		`CHK(b, 8'h34)
		scc_cpu_model_i.rd(ADDR_CMPA_H, b);
		`CHK(b, 8'h5c)
		scc_cpu_model_i.rd(ADDR_CNT_H, b);
		`CHK(b, 8'hab)
		scc_cpu_model_i.wr(ADDR_CMPB_L, 8'h02);
		scc_cpu_model_i.rd(ADDR_CMPB_H, b);
		`CHK(b, 8'hab)
		scc_cpu_model_i.wr16(ADDR_CNT_L, 16'hfffd);
		scc_cpu_model_i.wr(ADDR_MASK, 8'h24);
		scc_cpu_model_i.wr(ADDR_CTRL_B, ctlb(1'b0, 2'b00, CS_EXT_RISE));
		ext(3);
		scc_cpu_model_i.wr(ADDR_CTRL_B, ctlb(1'b0, 2'b00, CS_EXT_FALL));
		scc_cpu_model_i.rd16(ADDR_CNT_L, v);
		`CHK(v, 16'h0000)
		`CHK(atFloor, 1'b1)
		`CHK(overflowIrq, 1'b1)
		pulse(overflowAck);
		`CHK(overflowIrq, 1'b0)
		ext(2);
		scc_cpu_model_i.wr(ADDR_CTRL_B, ctlb(1'b0, 2'b00, CS_STOP));
		scc_cpu_model_i.rd16(ADDR_CNT_L, v);
		`CHK(v, 16'h0002)
		// The prescaler runs free, so a window of 80 edges holds exactly ten divide-by-8 ticks.
		scc_cpu_model_i.wr(ADDR_CTRL_B, ctlb(1'b0, 2'b00, CS_DIV8));
		idle(78);
		scc_cpu_model_i.wr(ADDR_CTRL_B, ctlb(1'b0, 2'b00, CS_STOP));
		scc_cpu_model_i.rd16(ADDR_CNT_L, v);
		`CHK(v, 16'h000c)
		scc_cpu_model_i.wr(ADDR_CTRL_A, 8'h01);
		scc_cpu_model_i.wr16(ADDR_CNT_L, 16'h00fe);
		scc_cpu_model_i.wr(ADDR_CTRL_B, ctlb(1'b0, 2'b00, CS_EXT_RISE));
		ext(1);
		`CHK(atCeiling, 1'b1)
		ext(2);
		scc_cpu_model_i.wr(ADDR_CTRL_A, 8'h00);
		scc_cpu_model_i.rd16(ADDR_CNT_L, v);
		`CHK(v, 16'h00fd)
		scc_cpu_model_i.wr(ADDR_CTRL_B, ctlb(1'b0, 2'b00, CS_CLK));
		// Ticks at every edge: the write edge is not counted, the next two are.
		scc_cpu_model_i.wr16(ADDR_CNT_L, 16'h1000);
		scc_cpu_model_i.wr(ADDR_CTRL_B, ctlb(1'b1, 2'b00, CS_STOP));
		scc_cpu_model_i.rd16(ADDR_CNT_L, v);
		`CHK(v, 16'h1002)
		scc_cpu_model_i.wr16(ADDR_CNT_L, 16'h4321);
		capturePin = 1'b1;
		waitIrq;
		scc_cpu_model_i.rd(ADDR_FLAGS, b);
		`CHK(b[FLAG_CAP], 1'b1)
		scc_cpu_model_i.rd16(ADDR_CAP_L, v);
		`CHK(v, 16'h4321)
		scc_cpu_model_i.wr(ADDR_FLAGS, 8'h20);
		idle(1);
		`CHK(captureIrq, 1'b0)
		scc_cpu_model_i.wr16(ADDR_CNT_L, 16'h5555);
		capturePin = 1'b0;
		idle(8);
		`CHK(captureIrq, 1'b0)
		comparatorSelect = 1'b1;
		idle(4);
		comparatorOutput = 1'b1;
		waitIrq;
		scc_cpu_model_i.rd16(ADDR_CAP_L, v);
		`CHK(v, 16'h5555)
		pulse(captureAck);
		`CHK(captureIrq, 1'b0)
		scc_cpu_model_i.wr(ADDR_MASK, 8'h04);
		comparatorOutput = 1'b0;
		idle(6);
		comparatorOutput = 1'b1;
		idle(8);
		`CHK(captureIrq, 1'b0)
		scc_cpu_model_i.rd(ADDR_FLAGS, b);
		`CHK(b[FLAG_CAP], 1'b1)
		scc_cpu_model_i.wr(ADDR_FLAGS, 8'h20);
		scc_cpu_model_i.wr(ADDR_MASK, 8'h24);
		scc_cpu_model_i.wr(ADDR_CTRL_B, ctlb(1'b1, 2'b00, CS_STOP) | 8'h80);
		comparatorOutput = 1'b0;
		idle(8);
		// A three-cycle spike must not pass the filter.
		comparatorOutput = 1'b1;
		idle(3);
		comparatorOutput = 1'b0;
		idle(8);
		`CHK(captureIrq, 1'b0)
		// Filtered capture lands four cycles later than the unfiltered two.
		comparatorOutput = 1'b1;
		idle(5);
		`CHK(captureIrq, 1'b0)
		idle(1);
		`CHK(captureIrq, 1'b1)
		scc_cpu_model_i.wr16(ADDR_CAP_L, 16'h1234);
		scc_cpu_model_i.rd16(ADDR_CAP_L, v);
		`CHK(v, 16'h5555)
		scc_cpu_model_i.wr(ADDR_CTRL_B, ctlb(1'b1, 2'b11, CS_STOP));
		scc_cpu_model_i.wr16(ADDR_CAP_L, 16'h1234);
		scc_cpu_model_i.rd16(ADDR_CAP_L, v);
		`CHK(v, 16'h1234)
		finish_test;
	end

	initial begin
		#2000000;
		fails++;
		finish_test;
	end
endmodule
